/* File: hw/cfm_pkg.sv */
// Package for the contact feedback monitor: timing constants, modes, lockout causes.
// Assumes a 50 MHz system clock on mclk_in.
`default_nettype none
package cfm_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  // Contact timing windows in milliseconds
  localparam int unsigned CLOSE_WIN_MS = 250;
  localparam int unsigned LEGACY_WIN_MS = 200;
  localparam int unsigned MISMATCH_MS = 250;
  // Longest times round down to whole cycles
  localparam int unsigned CLOSE_WIN_CYC = (CLK_HZ / 1000) * CLOSE_WIN_MS;
  localparam int unsigned LEGACY_WIN_CYC = (CLK_HZ / 1000) * LEGACY_WIN_MS;
  localparam int unsigned MISMATCH_CYC = (CLK_HZ / 1000) * MISMATCH_MS;
  localparam int unsigned TMR_W = 24;

  typedef enum logic [1:0] {
    CFM_MODE_NONE = 2'b00,
    CFM_MODE_SINGLE = 2'b01,
    CFM_MODE_DUAL = 2'b10
  } cfm_mode_t;

  // Factory value of the configuration switch
  localparam logic CFG_SW_RESET = 1'b1;

  typedef enum logic [1:0] {
    CFM_ST_OFF = 2'b00,
    CFM_ST_ON = 2'b01,
    CFM_ST_LOCK = 2'b10
  } cfm_state_t;

  // Lockout cause flags
  typedef struct packed {
    logic slow_close_a;
    logic slow_close_b;
    logic slow_open_a;
    logic mismatch;
  } cfm_cause_t;
  localparam cfm_cause_t CAUSE_RESET = 4'h0;

  // Feedback inputs: high means contact closed
  typedef struct packed {
    logic a;
    logic b;
  } cfm_fb_t;
endpackage : cfm_pkg
`default_nettype wire

/* File: hw/cfm_window_timer.sv */
// Window timer: counts while armed, flags expiry after a given cycle limit.
// Assumes limit is at least one cycle and fits in the counter width.
`default_nettype none
module cfm_window_timer #(
  parameter int unsigned W = 24
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic arm_in,
  input wire logic [W-1:0] limit_in,
  output logic expired_out
);
  import cfm_pkg::*;
  logic [W-1:0] cnt_reg;

  initial begin
    if (W < 2) $error("cfm_window_timer: width too small");
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg <= '0;
    end else if (!arm_in) begin
      cnt_reg <= '0;
    end else if (cnt_reg != limit_in) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Expiry means the condition persisted longer than the limit
  assign expired_out = arm_in && (cnt_reg == limit_in);
endmodule : cfm_window_timer
`default_nettype wire

/* File: hw/cfm_monitor.sv */
// Contact feedback monitor: gates reset and safety output turn-on on
// the forced-guided feedback contacts and locks out on timing faults.
// Assumes synchronous inputs, feedback high when contacts are closed.
`default_nettype none
// Operation
// RULE1 - Three modes: single-channel, dual-channel, or no monitoring, chosen by switches.
// RULE2 - Factory switch setting selects dual-channel monitoring.
// RULE3 - Installer wires both feedback inputs to match the selected mode.
// RULE4 - Monitored modes refuse reset and keep outputs off unless contacts are closed.
// RULE5 - Single-channel: feedback ignored while outputs are on.
// RULE6 - Single-channel: contacts must close within 250 ms after outputs turn off.
// RULE7 - Legacy single-channel: open within 200 ms of on, close within 200 ms of off.
// RULE8 - Dual-channel: both inputs changing together is always accepted.
// RULE9 - Dual-channel: inputs disagreeing over 250 ms cause lockout.
// RULE10 - Legacy dual-channel: each contact closes within 200 ms after outputs off.
// RULE11 - No monitoring: tie input A to B and choose the dual setting.
// RULE12 - Alternative no monitoring: single setting with input A held high.
// RULE13 - Auxiliary output available only in single-channel mode.
// RULE14 - Dual-channel diagnostics show which contact was slow or failed; code names a contact only for a legacy slow close, not on mismatch.
// RULE15 - Enabled auxiliary output mirrors the safety output state.
// RULE16 - Lockout holds outputs off until cleared, with its cause flagged.
module cfm_monitor #(
  parameter int unsigned CLOSE_CYC = cfm_pkg::CLOSE_WIN_CYC,
  parameter int unsigned LEGACY_CYC = cfm_pkg::LEGACY_WIN_CYC,
  parameter int unsigned MISM_CYC = cfm_pkg::MISMATCH_CYC
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic monitor_en_in,
  input wire logic dual_channel_setting_in,
  input wire logic legacy_variant_in,
  input wire logic run_request_in,
  input wire logic reset_request_in,
  input wire logic lockout_clear_in,
  input wire cfm_pkg::cfm_fb_t feedback_in,
  output logic [1:0] safety_output_pair_out,
  output logic aux_output_out,
  output logic aux_enabled_out,
  output logic lockout_out,
  output cfm_pkg::cfm_cause_t lockout_cause_out,
  output cfm_pkg::cfm_mode_t mode_out
);
  import cfm_pkg::*;

  initial begin
    if (CLOSE_CYC < 1 || CLOSE_CYC >= (1 << TMR_W)) $error("cfm_monitor: bad CLOSE_CYC");
    if (LEGACY_CYC < 1 || LEGACY_CYC >= (1 << TMR_W)) $error("cfm_monitor: bad LEGACY_CYC");
    if (MISM_CYC < 1 || MISM_CYC >= (1 << TMR_W)) $error("cfm_monitor: bad MISM_CYC");
  end

  cfm_state_t state_reg;
  cfm_state_t state_next;
  cfm_mode_t mode_reg;
  cfm_cause_t cause_reg;
  cfm_cause_t cause_next;
  logic sw_dual_reg;
  logic sw_mon_reg;
  logic strap_done_reg;
  logic [1:0] post_off_reg;
  logic post_on_reg;
  logic closed_ok;
  logic mismatch;
  logic close_arm_a;
  logic close_arm_b;
  logic open_arm;
  logic [TMR_W-1:0] close_lim;
  logic close_exp_a;
  logic close_exp_b;
  logic open_exp;
  logic mism_exp;
  logic fault;

  // Switches are caught on the first clock after reset release, since a
  // strap must not feed an asynchronous reset path.
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sw_dual_reg <= CFG_SW_RESET; // RULE2
      sw_mon_reg <= 1'b1;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      sw_dual_reg <= dual_channel_setting_in;
      sw_mon_reg <= monitor_en_in;
      strap_done_reg <= 1'b1;
    end
  end

  // Mode change only while outputs are off; a live swap could mask a fault
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_reg <= CFM_MODE_DUAL; // RULE2
    end else if (state_reg == CFM_ST_OFF) begin
      if (!sw_mon_reg) begin
        mode_reg <= CFM_MODE_NONE; // RULE1
      end else if (sw_dual_reg) begin
        mode_reg <= CFM_MODE_DUAL; // RULE1
      end else begin
        mode_reg <= CFM_MODE_SINGLE; // RULE1
      end
    end
  end

  // Input B is the auxiliary pin in single mode and is not read then
  always_comb begin
    case (mode_reg)
      CFM_MODE_SINGLE: closed_ok = feedback_in.a;
      CFM_MODE_DUAL: closed_ok = feedback_in.a && feedback_in.b;
      default: closed_ok = 1'b1;
    endcase
  end

  // Agreement of both inputs is never a mismatch fault, in any output state
  assign mismatch = (mode_reg == CFM_MODE_DUAL) && (feedback_in.a != feedback_in.b); // RULE8

  // Windows after turn-off, armed until the contact is seen closed
  assign close_arm_a = post_off_reg[0] && !feedback_in.a;
  assign close_arm_b = post_off_reg[1] && !feedback_in.b;
  assign close_lim = legacy_variant_in ? TMR_W'(LEGACY_CYC) : TMR_W'(CLOSE_CYC); // RULE7
  assign open_arm = post_on_reg && feedback_in.a;

  cfm_window_timer #(.W(TMR_W)) u_close_a (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .arm_in(close_arm_a),
    .limit_in(close_lim),
    .expired_out(close_exp_a)
  );

  cfm_window_timer #(.W(TMR_W)) u_close_b (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .arm_in(close_arm_b),
    .limit_in(TMR_W'(LEGACY_CYC)),
    .expired_out(close_exp_b)
  );

  cfm_window_timer #(.W(TMR_W)) u_open (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .arm_in(open_arm),
    .limit_in(TMR_W'(LEGACY_CYC)),
    .expired_out(open_exp)
  );

  cfm_window_timer #(.W(TMR_W)) u_mism (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .arm_in(mismatch),
    .limit_in(TMR_W'(MISM_CYC)),
    .expired_out(mism_exp)
  );

  // Track the post-transition windows per channel
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      post_off_reg <= 2'b00;
      post_on_reg <= 1'b0;
    end else begin
      if (state_reg == CFM_ST_ON && state_next == CFM_ST_OFF) begin
        case (mode_reg)
          CFM_MODE_SINGLE: post_off_reg <= 2'b01; // RULE6
          CFM_MODE_DUAL: post_off_reg <= {legacy_variant_in, legacy_variant_in}; // RULE10
          default: post_off_reg <= 2'b00;
        endcase
      end else if (state_next != CFM_ST_OFF) begin
        post_off_reg <= 2'b00;
      end else begin
        if (feedback_in.a) post_off_reg[0] <= 1'b0;
        if (feedback_in.b) post_off_reg[1] <= 1'b0;
      end
      if (state_reg == CFM_ST_OFF && state_next == CFM_ST_ON) begin
        post_on_reg <= (mode_reg == CFM_MODE_SINGLE) && legacy_variant_in; // RULE7
      end else if (state_next != CFM_ST_ON || !feedback_in.a) begin
        post_on_reg <= 1'b0;
      end
    end
  end

  // Single mode checks no feedback while on except the legacy open window
  always_comb begin
    cause_next = cause_reg;
    cause_next.slow_close_a = cause_reg.slow_close_a | close_exp_a; // RULE6
    cause_next.slow_close_b = cause_reg.slow_close_b | close_exp_b; // RULE14
    cause_next.slow_open_a = cause_reg.slow_open_a | open_exp; // RULE7
    cause_next.mismatch = cause_reg.mismatch | mism_exp; // RULE9
  end
  assign fault = close_exp_a || close_exp_b || open_exp || mism_exp;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CFM_ST_OFF: begin
        if (fault) begin
          state_next = CFM_ST_LOCK;
        end else if (reset_request_in && run_request_in && closed_ok) begin
          state_next = CFM_ST_ON; // RULE4
        end
      end
      CFM_ST_ON: begin
        if (fault) begin
          state_next = CFM_ST_LOCK;
        end else if (!run_request_in) begin
          state_next = CFM_ST_OFF;
        end
      end
      CFM_ST_LOCK: begin
        if (lockout_clear_in && !fault) begin
          state_next = CFM_ST_OFF; // RULE16
        end
      end
      default: state_next = CFM_ST_LOCK;
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= CFM_ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // A new fault in the clearing cycle wins over the clear
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cause_reg <= CAUSE_RESET;
    end else if (state_reg == CFM_ST_LOCK && state_next == CFM_ST_OFF) begin
      cause_reg <= CAUSE_RESET; // RULE16
    end else begin
      cause_reg <= cause_next; // RULE16
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      safety_output_pair_out <= 2'b00;
      aux_output_out <= 1'b0;
      aux_enabled_out <= 1'b0;
    end else begin
      safety_output_pair_out <= (state_next == CFM_ST_ON) ? 2'b11 : 2'b00; // RULE16
      aux_enabled_out <= (mode_reg == CFM_MODE_SINGLE); // RULE13
      aux_output_out <= (mode_reg == CFM_MODE_SINGLE) && (state_next == CFM_ST_ON); // RULE15
    end
  end

  assign lockout_out = (state_reg == CFM_ST_LOCK);
  assign lockout_cause_out = cause_reg;
  assign mode_out = mode_reg;
endmodule : cfm_monitor
`default_nettype wire

/* File: tb/cfm_monitor_chk.sv */
// Assertions on the contact feedback monitor ports, bound to cfm_monitor.
// Assumes one clock domain and the shortened windows handed on by the bind.
`default_nettype none
module cfm_monitor_chk import cfm_pkg::*; #(
  parameter int unsigned CLOSE_CYC = 20,
  parameter int unsigned LEGACY_CYC = 16,
  parameter int unsigned MISM_CYC = 20
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic legacy_variant_in,
  input wire logic run_request_in,
  input wire logic reset_request_in,
  input wire logic lockout_clear_in,
  input wire cfm_pkg::cfm_fb_t feedback_in,
  input wire logic [1:0] safety_output_pair_out,
  input wire logic aux_output_out,
  input wire logic aux_enabled_out,
  input wire logic lockout_out,
  input wire cfm_pkg::cfm_cause_t lockout_cause_out,
  input wire cfm_pkg::cfm_mode_t mode_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // Consecutive cycles of disagreement seen in dual mode
  int unsigned mism_cnt;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) mism_cnt <= 0;
    else if (mode_out == CFM_MODE_DUAL && feedback_in.a != feedback_in.b) mism_cnt <= mism_cnt + 1;
    else mism_cnt <= 0;
  end
  property p_lock_off; lockout_out |-> safety_output_pair_out == 2'b00; endproperty
  a_lock_off: assert property (p_lock_off) else $error("outputs on in lockout");
  property p_hold_lock; lockout_out && !lockout_clear_in |=> lockout_out; endproperty
  a_hold_lock: assert property (p_hold_lock) else $error("lockout left uncleared");
  property p_cause; $rose(lockout_out) |-> ##[0:1] lockout_cause_out != CAUSE_RESET; endproperty
  a_cause: assert property (p_cause) else $error("lockout without cause");
  property p_turn_on;
    $rose(safety_output_pair_out[0]) |-> $past(run_request_in && reset_request_in) &&
      (mode_out == CFM_MODE_NONE || $past(feedback_in.a) &&
      (mode_out == CFM_MODE_SINGLE || $past(feedback_in.b)));
  endproperty
  a_turn_on: assert property (p_turn_on) else $error("turn-on with open contacts");
  property p_single_hold;
    mode_out == CFM_MODE_SINGLE && !legacy_variant_in && safety_output_pair_out == 2'b11 &&
      run_request_in |=> safety_output_pair_out == 2'b11;
  endproperty
  a_single_hold: assert property (p_single_hold) else $error("single mode dropped");
  property p_aux; aux_output_out == (aux_enabled_out && safety_output_pair_out == 2'b11); endproperty
  a_aux: assert property (p_aux) else $error("aux output wrong");
  // The enable is registered from the mode, so it trails a mode change by one clock
  property p_aux_en; aux_enabled_out == ($past(mode_out) == CFM_MODE_SINGLE); endproperty
  a_aux_en: assert property (p_aux_en) else $error("aux enable wrong");
  property p_mism_lock; mism_cnt == MISM_CYC + 3 |-> lockout_out; endproperty
  a_mism_lock: assert property (p_mism_lock) else $error("no mismatch lockout");
  property p_no_early;
    $rose(lockout_out) && mode_out == CFM_MODE_DUAL && !legacy_variant_in |-> mism_cnt >= MISM_CYC;
  endproperty
  a_no_early: assert property (p_no_early) else $error("early dual lockout");
  c_on: cover property ($rose(safety_output_pair_out[0]));
  c_lock: cover property ($rose(lockout_out));
  c_aux: cover property (aux_output_out);
endmodule // cfm_monitor_chk
`default_nettype wire

/* File: tb/cfm_contacts.sv */
// Model of forced-guided relay feedback contacts, high when closed.
// Assumes the safety outputs drive the coils; lags count clock cycles.
`default_nettype none
module cfm_contacts (
  input wire logic mclk_in,
  input wire logic [1:0] drive_in,
  input var int lag_a_in,
  input var int lag_b_in,
  input wire logic [1:0] weld_in,
  input wire logic [1:0] tie_in,
  output cfm_pkg::cfm_fb_t feedback_out
);
  import cfm_pkg::*;
  logic [1:0] shut_reg = 2'b11;
  int cnt_reg [2] = '{0, 0};
  int lag [2];
  always_comb begin
    lag[1] = lag_a_in;
    lag[0] = lag_b_in;
  end
  // Each contact follows its own coil after its lag, so equal lags move both together
  always_ff @(posedge mclk_in) begin
    for (int i = 0; i < 2; i++) begin
      if (shut_reg[i] == !drive_in[i]) cnt_reg[i] <= 0;
      else if (cnt_reg[i] >= lag[i]) shut_reg[i] <= !drive_in[i];
      else cnt_reg[i] <= cnt_reg[i] + 1;
    end
  end
  // A welded main contact holds its monitoring contact open; jumpers stand for
  // installer wiring: bit 1 holds input A at the supply, bit 0 ties B to A
  always_comb begin
    feedback_out = ~weld_in & shut_reg;
    if (tie_in[1]) feedback_out.a = 1'b1;
    if (tie_in[0]) feedback_out.b = feedback_out.a;
  end
endmodule // cfm_contacts
`default_nettype wire

/* File: tb/cfm_monitor_tb_top.sv */
// Self-checking bench for the contact feedback monitor with a relay model.
// Assumes windows shortened to 20, 16 and 20 cycles.
`default_nettype none
module cfm_monitor_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import cfm_pkg::*;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic en = 1'b1, dual = 1'b1, leg = 1'b0, run = 1'b0, rq = 1'b0, clr = 1'b0;
  logic [1:0] weld = 2'b00;
  logic [1:0] tie = 2'b00;
  int lag_a = 3, lag_b = 3, bad_count = 0, comparisons = 0;
  cfm_fb_t fb;
  logic [1:0] outs;
  logic aux, aux_en, lock;
  cfm_cause_t cause;
  cfm_mode_t mode;
  always #10 mclk_in = ~mclk_in;
  cfm_monitor #(.CLOSE_CYC(20), .LEGACY_CYC(16), .MISM_CYC(20)) cfm_monitor_inst (
    .mclk_in(mclk_in), .rst_in(rst_in), .monitor_en_in(en), .dual_channel_setting_in(dual),
    .legacy_variant_in(leg), .run_request_in(run), .reset_request_in(rq),
    .lockout_clear_in(clr), .feedback_in(fb), .safety_output_pair_out(outs),
    .aux_output_out(aux), .aux_enabled_out(aux_en), .lockout_out(lock),
    .lockout_cause_out(cause), .mode_out(mode));
  cfm_contacts cfm_contacts_inst (.mclk_in(mclk_in), .drive_in(outs), .lag_a_in(lag_a),
    .lag_b_in(lag_b), .weld_in(weld), .tie_in(tie), .feedback_out(fb));
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic restart(input logic e, input logic d, input logic l);
    en = e;
    dual = d;
    leg = l;
    run = 1'b0;
    weld = 2'b00;
    tie = 2'b00;
    lag_a = 3;
    lag_b = 3;
    rst_in = 1'b1;
    cyc(2);
    rst_in = 1'b0;
    cyc(3);
  endtask
  task automatic go();
    run = 1'b1;
    rq = 1'b1;
    cyc(1);
    rq = 1'b0;
    cyc(2);
  endtask
  // Bounded wait; a lockout that never comes ends the run
  task automatic wait_lock(input int n);
    for (int i = 0; i < n && lock !== 1'b1; i++) cyc(1);
    chk("lockout", lock, 4'h1);
    if (lock !== 1'b1) close_out();
  endtask
  task automatic t_dual();
    restart(1'b1, CFG_SW_RESET, 1'b0);
    chk("mode", mode, CFM_MODE_DUAL);
    chk("aux_en", aux_en, 4'h0);
    go();
    chk("outputs", outs, 4'h3);
    cyc(40);
    run = 1'b0;
    cyc(40);
    chk("lockout", lock, 4'h0);
    $display("t_dual done");
  endtask
  task automatic t_mism();
    restart(1'b1, 1'b1, 1'b0);
    weld = 2'b01;
    cyc(3);
    go();
    chk("outputs", outs, 4'h0);
    wait_lock(30);
    chk("cause", cause, 4'h1);
    clr = 1'b1;
    cyc(2);
    chk("lockout", lock, 4'h1);
    weld = 2'b00;
    cyc(8);
    chk("lockout", lock, 4'h0);
    clr = 1'b0;
    $display("t_mism done");
  endtask
  task automatic t_dual_leg();
    restart(1'b1, 1'b1, 1'b1);
    go();
    cyc(10);
    lag_b = 18;
    run = 1'b0;
    wait_lock(40);
    chk("slow channel", cause[3:2], 4'h1);
    $display("t_dual_leg done");
  endtask
  task automatic t_single();
    restart(1'b1, 1'b0, 1'b0);
    chk("mode", mode, CFM_MODE_SINGLE);
    chk("aux_en", aux_en, 4'h1);
    weld = 2'b10;
    cyc(3);
    go();
    chk("outputs", outs, 4'h0);
    weld = 2'b00;
    cyc(5);
    go();
    chk("aux", aux, 4'h1);
    weld = 2'b10;
    cyc(30);
    chk("outputs", outs, 4'h3);
    run = 1'b0;
    cyc(15);
    chk("aux", aux, 4'h0);
    chk("lockout", lock, 4'h0);
    wait_lock(20);
    chk("cause", cause, 4'h8);
    $display("t_single done");
  endtask
  task automatic t_single_leg();
    restart(1'b1, 1'b0, 1'b1);
    lag_a = 30;
    go();
    wait_lock(30);
    chk("cause", cause, 4'h2);
    $display("t_single_leg done");
  endtask
  task automatic t_none();
    restart(1'b0, 1'b1, 1'b0);
    chk("mode", mode, CFM_MODE_NONE);
    weld = 2'b11;
    cyc(3);
    go();
    chk("outputs", outs, 4'h3);
    cyc(40);
    chk("lockout", lock, 4'h0);
    $display("t_none done");
  endtask
  // Jumper wiring for no monitoring: B tied to A on the dual setting, then A
  // held at the supply on the single setting with its own contact stuck open
  task automatic t_jumper();
    restart(1'b1, 1'b1, 1'b0);
    tie = 2'b01;
    weld = 2'b01;
    cyc(3);
    go();
    chk("outputs", outs, 4'h3);
    run = 1'b0;
    cyc(40);
    chk("lockout", lock, 4'h0);
    restart(1'b1, 1'b0, 1'b0);
    tie = 2'b10;
    weld = 2'b10;
    cyc(3);
    go();
    chk("aux", aux, 4'h1);
    run = 1'b0;
    cyc(40);
    chk("lockout", lock, 4'h0);
    $display("t_jumper done");
  endtask
  initial begin
    t_dual();
    t_mism();
    t_dual_leg();
    t_single();
    t_single_leg();
    t_none();
    t_jumper();
    close_out();
  end
endmodule // cfm_monitor_tb_top
bind cfm_monitor cfm_monitor_chk #(.CLOSE_CYC(CLOSE_CYC), .LEGACY_CYC(LEGACY_CYC),
  .MISM_CYC(MISM_CYC)) cfm_monitor_chk_inst (.mclk_in(mclk_in), .rst_in(rst_in),
  .legacy_variant_in(legacy_variant_in), .run_request_in(run_request_in),
  .reset_request_in(reset_request_in), .lockout_clear_in(lockout_clear_in),
  .feedback_in(feedback_in), .safety_output_pair_out(safety_output_pair_out),
  .aux_output_out(aux_output_out), .aux_enabled_out(aux_enabled_out),
  .lockout_out(lockout_out), .lockout_cause_out(lockout_cause_out), .mode_out(mode_out));
`default_nettype wire
